// file: rtl/cbs_dev.sv
// clock fan-out buffer with smbus configuration slave
// Function
// [R01] all outputs enabled after power-up
// [R02] registers reset to defaults on reset
// [R03] host enables or disables each pair
// [R04] byte write, byte read, block write, block read
// [R05] block bytes ascend from zero, msb first
// [R06] stop after any byte keeps finished bytes
// [R07] bus address chosen by address pin
// [R08] command bit 7 selects single or block
// [R09] command bits 6:5 match select pin
// [R10] command bits 4:0 give byte offset
// [R11] zero command is block from byte zero; the code refuses it, as bits 6:5 of zero never match the select code
// [R12] block write: addr, cmd, count, data, ack
// [R13] block read: count then data, nack ends
// [R14] true outputs copy bank reference
// [R15] complement outputs invert bank reference
// [R16] per bank feedback follows reference
// [R17] enable bit 1 active, default 1
// [R18] feedback bit 0 enables, default 0
// [R19] single byte transfers use byte data protocol
// [R20] ignore wrong address or select bits
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cbs_cfg.svh"
module cbs_dev (
   input wire logic pclk,
   input wire logic presetn,
   cbs_if.dev link,
   input wire logic address_choice_pin,
   input wire logic device_select_pin,
   input wire logic bank_a_reference_in,
   input wire logic bank_b_reference_in,
   output logic [5:0] bank_a_true_outputs,
   output logic [5:0] bank_a_complement_outputs,
   output logic [5:0] bank_b_true_outputs,
   output logic [5:0] bank_b_complement_outputs,
   output logic bank_a_feedback_out,
   output logic bank_b_feedback_out
);
   import cbs_pkg::*;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [5:0] sy1_r;
   logic [5:0] sy2_r;
   logic scl_d_r;
   logic sda_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_r <= 6'h3f;
         sy2_r <= 6'h3f;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         sy1_r <= {link.scl, link.sda, address_choice_pin,
                   device_select_pin, bank_a_reference_in,
                   bank_b_reference_in};
         sy2_r <= sy1_r;
         scl_d_r <= sy2_r[5];
         sda_d_r <= sy2_r[4];
      end
   end
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl_s = sy2_r[5];
   assign sda_s = sy2_r[4];
   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;
   assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

   // ---------------------------------------------------------------
   // configuration bytes
   // ---------------------------------------------------------------
   logic [7:0] regs_r [0:23];
   cbs_dst_e st_r;
   cbs_stage_e stage_r;
   logic [2:0] cnt_r;
   logic [7:0] sh_r;
   logic [4:0] ptr_r;
   logic [7:0] rx_byte;
   logic byte_done;
   logic wr_now;
   assign rx_byte = {sh_r[6:0], sda_s};
   assign byte_done = (st_r == D_RX) && scl_rise && (cnt_r == `CBS_LAST_BIT);
   assign wr_now = byte_done && (stage_r == G_DATA);

   function automatic logic [7:0] reg_default(input int idx);
      if (idx == int'(`CBS_EN_HI))
         return `CBS_DEF_HI;
      else if (idx == int'(`CBS_EN_LO))
         return `CBS_DEF_LO;
      else
         return `CBS_DEF_ZERO;
   endfunction

   function automatic logic in_map(input logic [4:0] p);
      return {3'h0, p} < `CBS_NREGS;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 24; i++) begin
            regs_r[i] <= reg_default(i); // [R01] [R02] [R17] [R18]
         end
      end else if (wr_now && in_map(ptr_r)) begin
         regs_r[ptr_r] <= rx_byte; // [R03] [R06]
      end
   end

   // ---------------------------------------------------------------
   // serial protocol engine
   // ---------------------------------------------------------------
   logic [6:0] my_addr;
   logic [1:0] cs_code;
   logic ack_half_r;
   logic rd_r;
   logic cnt_first_r;
   logic mack_r;
   logic oe_r;
   logic [7:0] tx_byte;
   assign my_addr = sy2_r[3] ? `CBS_ADDR_SEL1 : `CBS_ADDR_SEL0; // [R07]
   assign cs_code = sy2_r[2] ? `CBS_CS_HIGH : `CBS_CS_LOW; // [R09]
   // block read sends the byte count first
   assign tx_byte = cnt_first_r ? `CBS_NREGS :
                    (in_map(ptr_r) ? regs_r[ptr_r] : `CBS_DEF_ZERO); // [R13]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= D_IDLE;
         stage_r <= G_ADDR;
         cnt_r <= 3'h0;
         sh_r <= 8'h00;
         ptr_r <= 5'h00;
         ack_half_r <= 1'b0;
         rd_r <= 1'b0;
         cnt_first_r <= 1'b0;
         mack_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (start_c) begin
         st_r <= D_RX;
         stage_r <= G_ADDR;
         cnt_r <= 3'h0;
         oe_r <= 1'b0;
         ack_half_r <= 1'b0;
      end else if (stop_c) begin
         st_r <= D_IDLE; // [R06]
         oe_r <= 1'b0;
      end else begin
         unique case (st_r)
            D_IDLE: begin
               oe_r <= 1'b0;
            end
            D_RX: begin
               if (scl_rise) begin
                  sh_r <= rx_byte;
                  cnt_r <= cnt_r + 3'h1;
               end
               if (byte_done) begin
                  st_r <= D_RACK; // [R12]
                  unique case (stage_r)
                     G_ADDR: begin
                        if (rx_byte[7:1] != my_addr) begin
                           st_r <= D_IDLE; // [R20]
                        end
                        rd_r <= rx_byte[0];
                        stage_r <= G_CMD;
                     end
                     G_CMD: begin
                        if (rx_byte[6:5] != cs_code) begin
                           st_r <= D_IDLE; // [R20]
                        end
                        // [R08] [R10] [R11]
                        if (rx_byte[`CBS_CMD_SINGLE]) begin
                           ptr_r <= rx_byte[4:0];
                           stage_r <= G_DATA; // [R19]
                           cnt_first_r <= 1'b0;
                        end else begin
                           ptr_r <= 5'h00;
                           stage_r <= G_CNT;
                           cnt_first_r <= 1'b1;
                        end
                     end
                     G_CNT: begin
                        stage_r <= G_DATA;
                     end
                     G_DATA: begin
                        ptr_r <= ptr_r + 5'h01; // [R05]
                     end
                  endcase
               end
            end
            D_RACK: begin
               if (scl_fall) begin
                  if (!ack_half_r) begin
                     oe_r <= 1'b1;
                     ack_half_r <= 1'b1;
                  end else begin
                     ack_half_r <= 1'b0;
                     cnt_r <= 3'h0;
                     if (rd_r && stage_r == G_CMD) begin
                        sh_r <= tx_byte;
                        oe_r <= !tx_byte[7]; // [R05]
                        st_r <= D_TX;
                        if (cnt_first_r) begin
                           cnt_first_r <= 1'b0;
                        end else begin
                           ptr_r <= ptr_r + 5'h01;
                        end
                     end else begin
                        oe_r <= 1'b0;
                        st_r <= D_RX;
                     end
                  end
               end
            end
            D_TX: begin
               if (scl_fall) begin
                  if (cnt_r == `CBS_LAST_BIT) begin
                     oe_r <= 1'b0;
                     st_r <= D_TACK;
                  end else begin
                     sh_r <= {sh_r[6:0], 1'b0};
                     oe_r <= !sh_r[6];
                     cnt_r <= cnt_r + 3'h1;
                  end
               end
            end
            D_TACK: begin
               if (scl_rise) begin
                  mack_r <= sda_s;
               end
               if (scl_fall) begin
                  cnt_r <= 3'h0;
                  if (mack_r) begin
                     st_r <= D_IDLE; // [R13]
                  end else begin
                     sh_r <= tx_byte;
                     oe_r <= !tx_byte[7];
                     st_r <= D_TX;
                     if (cnt_first_r) begin
                        cnt_first_r <= 1'b0;
                     end else begin
                        ptr_r <= ptr_r + 5'h01; // [R05]
                     end
                  end
               end
            end
            default: begin
               st_r <= D_IDLE;
            end
         endcase
      end
   end
   assign link.d_sda_o = 1'b0;
   assign link.d_sda_oe = oe_r;

   // ---------------------------------------------------------------
   // clock outputs
   // ---------------------------------------------------------------
   logic [11:0] en;
   assign en = {regs_r[`CBS_EN_LO][3:0], regs_r[`CBS_EN_HI]};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_a_true_outputs <= 6'h00;
         bank_a_complement_outputs <= 6'h00;
         bank_b_true_outputs <= 6'h00;
         bank_b_complement_outputs <= 6'h00;
         bank_a_feedback_out <= 1'b0;
         bank_b_feedback_out <= 1'b0;
      end else begin
         // inactive pairs drive both legs low
         bank_a_true_outputs <= en[5:0] & {6{sy2_r[1]}}; // [R14] [R17]
         bank_a_complement_outputs <= en[5:0] & {6{!sy2_r[1]}}; // [R15]
         bank_b_true_outputs <= en[11:6] & {6{sy2_r[0]}}; // [R14]
         bank_b_complement_outputs <= en[11:6] & {6{!sy2_r[0]}}; // [R15]
         bank_a_feedback_out <= sy2_r[1] &&
            !regs_r[`CBS_EN_LO][`CBS_FBA_BIT]; // [R16] [R18]
         bank_b_feedback_out <= sy2_r[0] &&
            !regs_r[`CBS_EN_LO][`CBS_FBB_BIT]; // [R16] [R18]
      end
   end
endmodule
`default_nettype wire

// file: rtl/cbs_cfg.svh
// constants for the clock buffer smbus configuration port
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH
`define CBS_ADDR_SEL1 7'h69
`define CBS_ADDR_SEL0 7'h6e
`define CBS_CS_LOW 2'h1
`define CBS_CS_HIGH 2'h2
`define CBS_NREGS 8'h18
`define CBS_EN_HI 5'h17
`define CBS_EN_LO 5'h16
`define CBS_DEF_HI 8'hff
`define CBS_DEF_LO 8'h0f
`define CBS_DEF_ZERO 8'h00
`define CBS_FBA_BIT 5
`define CBS_FBB_BIT 4
`define CBS_CMD_SINGLE 7
`define CBS_LAST_BIT 3'h7
`define CBS_ACK_BIT 4'h8
// scl period in ns and the quarter period in pclk cycles
`define CBS_SCL_NS 2500
`define CBS_PCLK_NS 8
`define CBS_Q_CYC (`CBS_SCL_NS / 4 / `CBS_PCLK_NS)
// host apb map
`define CBS_A_CTRL 8'h00
`define CBS_A_XFER 8'h04
`define CBS_A_STAT 8'h08
`define CBS_A_DATA 8'h80
`endif

// file: rtl/cbs_pkg.sv
// types for the clock buffer smbus configuration port
package cbs_pkg;
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_RX = 3'b001,
      D_RACK = 3'b010,
      D_TX = 3'b011,
      D_TACK = 3'b100
   } cbs_dst_e;
   typedef enum logic [1:0] {
      G_ADDR = 2'b00,
      G_CMD = 2'b01,
      G_CNT = 2'b10,
      G_DATA = 2'b11
   } cbs_stage_e;
   typedef enum logic [1:0] {
      OP_BWR = 2'b00,
      OP_BRD = 2'b01,
      OP_KWR = 2'b10,
      OP_KRD = 2'b11
   } cbs_op_e;
   typedef enum logic [1:0] {
      I_IDLE = 2'b00,
      I_START = 2'b01,
      I_BYTE = 2'b10,
      I_STOP = 2'b11
   } cbs_item_e;
   typedef enum logic [2:0] {
      S_ADDRW = 3'b000,
      S_CMD = 3'b001,
      S_CNT = 3'b010,
      S_WDATA = 3'b011,
      S_RS = 3'b100,
      S_ADDRR = 3'b101,
      S_RCNT = 3'b110,
      S_RDATA = 3'b111
   } cbs_step_e;
endpackage

// file: rtl/cbs_if.sv
// two-wire link between the smbus host and the clock buffer
`timescale 1ns/1ps
`default_nettype none
interface cbs_if;
   logic scl;
   logic h_sda_o;
   logic h_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   wire sda;
   // open-drain line with pull-up
   assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));
   modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
   modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface
`default_nettype wire

// file: rtl/cbs_host.sv
// smbus host controller for the clock buffer, apb programmed
`timescale 1ns/1ps
`default_nettype none
`include "cbs_cfg.svh"
module cbs_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   cbs_if.host link
);
   import cbs_pkg::*;

   // ---------------------------------------------------------------
   // apb registers
   // ---------------------------------------------------------------
   logic [7:0] buf_r [0:31];
   cbs_op_e op_r;
   logic [6:0] sla_r;
   logic [7:0] cmd_r;
   logic [4:0] n_r;
   logic [7:0] rcnt_r;
   logic nack_r;
   logic busy;
   logic wr_acc;
   logic go;
   logic is_data;
   logic mapped;
   cbs_item_e item_r;
   cbs_step_e step_r;
   logic [4:0] idx_r;
   logic [7:0] rx_r;
   logic bdone;
   assign busy = item_r != I_IDLE;
   assign is_data = paddr[7];
   assign mapped = is_data || paddr == `CBS_A_CTRL ||
                   paddr == `CBS_A_XFER || paddr == `CBS_A_STAT;
   assign wr_acc = psel && penable && pwrite;
   assign go = wr_acc && paddr == `CBS_A_CTRL && pwdata[0] && !busy;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   always_comb begin
      prdata = 32'h0000_0000;
      if (is_data)
         prdata = {24'h00_0000, buf_r[paddr[6:2]]};
      else if (paddr == `CBS_A_CTRL)
         prdata = {29'h0000_0000, op_r, 1'b0};
      else if (paddr == `CBS_A_XFER)
         prdata = {11'h000, n_r, cmd_r, 1'b0, sla_r};
      else if (paddr == `CBS_A_STAT)
         prdata = {16'h0000, rcnt_r, 6'h00, nack_r, busy};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_r <= OP_BWR;
         sla_r <= `CBS_ADDR_SEL0;
         cmd_r <= 8'h00;
         n_r <= 5'h00;
      end else if (wr_acc && !busy) begin
         if (paddr == `CBS_A_CTRL)
            op_r <= cbs_op_e'(pwdata[2:1]);
         if (paddr == `CBS_A_XFER) begin
            sla_r <= pwdata[6:0];
            cmd_r <= pwdata[15:8];
            n_r <= pwdata[20:16];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 32; i++) begin
            buf_r[i] <= 8'h00;
         end
      end else if (wr_acc && is_data && !busy) begin
         buf_r[paddr[6:2]] <= pwdata[7:0];
      end else if (bdone && step_r == S_RDATA) begin
         buf_r[idx_r] <= rx_r;
      end
   end

   // ---------------------------------------------------------------
   // bit engine, four quarters per scl period
   // ---------------------------------------------------------------
   localparam int QC = `CBS_Q_CYC;
   logic [11:0] qdiv_r;
   logic tick;
   logic [1:0] q_r;
   logic [3:0] bi_r;
   logic [7:0] tx_r;
   logic last_r;
   logic ackb_r;
   logic scl_r;
   logic oe_r;
   logic sda1_r;
   logic sda2_r;
   logic host_tx;
   assign tick = qdiv_r == 12'(QC - 1);
   assign host_tx = step_r != S_RCNT && step_r != S_RDATA;
   assign bdone = tick && item_r == I_BYTE && q_r == 2'h3 &&
                  bi_r == `CBS_ACK_BIT;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qdiv_r <= 12'h000;
         sda1_r <= 1'b1;
         sda2_r <= 1'b1;
      end else begin
         qdiv_r <= tick ? 12'h000 : qdiv_r + 12'h001;
         sda1_r <= link.sda;
         sda2_r <= sda1_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         item_r <= I_IDLE;
         step_r <= S_ADDRW;
         q_r <= 2'h0;
         bi_r <= 4'h0;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         idx_r <= 5'h00;
         last_r <= 1'b0;
         ackb_r <= 1'b0;
         rcnt_r <= 8'h00;
         nack_r <= 1'b0;
         scl_r <= 1'b1;
         oe_r <= 1'b0;
      end else if (go) begin
         item_r <= I_START;
         step_r <= S_ADDRW;
         q_r <= 2'h0;
         nack_r <= 1'b0;
         idx_r <= 5'h00;
      end else if (tick && busy) begin
         q_r <= q_r + 2'h1;
         unique case (q_r)
            2'h0: begin
               scl_r <= 1'b0;
               if (item_r == I_START)
                  oe_r <= 1'b0;
               else if (item_r == I_STOP)
                  oe_r <= 1'b1;
               else if (bi_r != `CBS_ACK_BIT)
                  oe_r <= host_tx && !tx_r[7 - bi_r[2:0]];
               else
                  oe_r <= !host_tx && !last_r;
            end
            2'h1: begin
               scl_r <= 1'b1;
            end
            2'h2: begin
               if (item_r == I_START)
                  oe_r <= 1'b1;
               else if (item_r == I_STOP)
                  oe_r <= 1'b0;
               else if (bi_r != `CBS_ACK_BIT)
                  rx_r <= {rx_r[6:0], sda2_r};
               else
                  ackb_r <= sda2_r;
            end
            2'h3: begin
               if (item_r != I_STOP)
                  scl_r <= 1'b0;
               bi_r <= 4'h0;
               if (item_r == I_STOP) begin
                  item_r <= I_IDLE;
               end else if (item_r == I_START) begin
                  item_r <= I_BYTE;
                  tx_r <= {sla_r, step_r == S_RS};
                  step_r <= (step_r == S_RS) ? S_ADDRR : S_ADDRW;
               end else if (bi_r != `CBS_ACK_BIT) begin
                  bi_r <= bi_r + 4'h1;
               end else if (host_tx && ackb_r) begin
                  nack_r <= 1'b1;
                  item_r <= I_STOP;
               end else begin
                  unique case (step_r)
                     S_ADDRW: begin
                        step_r <= S_CMD;
                        tx_r <= cmd_r;
                     end
                     S_CMD: begin
                        if (op_r == OP_BRD || op_r == OP_KRD) begin
                           step_r <= S_RS;
                           item_r <= I_START;
                        end else if (op_r == OP_BWR) begin
                           step_r <= S_WDATA;
                           tx_r <= buf_r[0];
                        end else begin
                           step_r <= S_CNT;
                           tx_r <= {3'h0, n_r};
                        end
                     end
                     S_CNT: begin
                        step_r <= S_WDATA;
                        tx_r <= buf_r[0];
                        if (n_r == 5'h00)
                           item_r <= I_STOP;
                     end
                     S_WDATA: begin
                        idx_r <= idx_r + 5'h01;
                        tx_r <= buf_r[idx_r + 5'h01];
                        if (op_r == OP_BWR || idx_r + 5'h01 == n_r)
                           item_r <= I_STOP;
                     end
                     S_ADDRR: begin
                        step_r <= (op_r == OP_BRD) ? S_RDATA : S_RCNT;
                        last_r <= op_r == OP_BRD || n_r == 5'h00;
                     end
                     S_RCNT: begin
                        rcnt_r <= rx_r;
                        step_r <= S_RDATA;
                        last_r <= n_r == 5'h01;
                        if (last_r)
                           item_r <= I_STOP;
                     end
                     S_RDATA: begin
                        idx_r <= idx_r + 5'h01;
                        last_r <= idx_r + 5'h02 == n_r;
                        if (last_r)
                           item_r <= I_STOP;
                     end
                     default: begin
                        item_r <= I_STOP;
                     end
                  endcase
               end
            end
         endcase
      end
   end
   assign link.scl = scl_r;
   assign link.h_sda_o = 1'b0;
   assign link.h_sda_oe = oe_r;
endmodule
`default_nettype wire

// file: verif/cbs_link_assertions.sv
// link checker for the smbus wires between host and buffer
`timescale 1ns/1ps
`default_nettype none
`include "cbs_cfg.svh"
module cbs_link_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl,
   input wire logic h_sda_o,
   input wire logic h_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic sda
);
   localparam int QC = `CBS_Q_CYC;
   logic [11:0] hi_r;
   logic [11:0] lo_r;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---
   // scl phase lengths, saturating
   // ---
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_r <= 12'h000;
         lo_r <= 12'h000;
      end else begin
         hi_r <= scl ? hi_r + {11'h000, ~&hi_r} : 12'h000;
         lo_r <= scl ? 12'h000 : lo_r + {11'h000, ~&lo_r};
      end
   end
   ack_low_a: assert property ($rose(d_sda_oe) |-> !scl)
      else $error("device took sda while scl high");
   rel_low_a: assert property ($fell(d_sda_oe) |-> !scl)
      else $error("device let sda go while scl high");
   ack_hold_a: assert property ($rose(d_sda_oe) |-> d_sda_oe [*8])
      else $error("device pull too short");
   open_drain_a: assert property (!d_sda_o && !h_sda_o)
      else $error("sda data not low");
   no_start_a: assert property (scl && $fell(sda) |-> !d_sda_oe)
      else $error("device made a start");
   quiet_stop_a: assert property (scl && $rose(sda) |=> !d_sda_oe [*8])
      else $error("device drove after stop");
   scl_high_a: assert property ($fell(scl) |-> hi_r >= QC)
      else $error("scl high phase short");
   scl_low_a: assert property ($rose(scl) |-> lo_r >= QC)
      else $error("scl low phase short");
endmodule
`default_nettype wire

// file: verif/tb.sv
// bench: apb host drives the clock buffer over smbus
`timescale 1ns/1ps
`default_nettype none
`include "cbs_cfg.svh"
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic address_choice_pin = 1'b0;
   logic device_select_pin = 1'b0;
   logic ra = 1'b0;
   logic rb = 1'b0;
   logic [5:0] at, ac, bt, bc;
   logic fa, fb;
   int failures = 0;
   int checks = 0;
   logic [31:0] q;
   cbs_if lnk ();
   cbs_host u_cbs_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(), .link(lnk));
   cbs_dev u_cbs_dev (.pclk(pclk), .presetn(presetn), .link(lnk),
      .address_choice_pin(address_choice_pin),
      .device_select_pin(device_select_pin),
      .bank_a_reference_in(ra), .bank_b_reference_in(rb),
      .bank_a_true_outputs(at), .bank_a_complement_outputs(ac),
      .bank_b_true_outputs(bt), .bank_b_complement_outputs(bc),
      .bank_a_feedback_out(fa), .bank_b_feedback_out(fb));
   cbs_link_assertions u_cbs_link_assertions (.pclk(pclk),
      .presetn(presetn), .scl(lnk.scl), .h_sda_o(lnk.h_sda_o),
      .h_sda_oe(lnk.h_sda_oe), .d_sda_o(lnk.d_sda_o),
      .d_sda_oe(lnk.d_sda_oe), .sda(lnk.sda));
   always #4 pclk = ~pclk;
   // ---
   // shared tasks
   // ---
   task automatic wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e,
         input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one transfer with one data byte, then poll until idle
   task automatic run(input logic [1:0] op, input logic [6:0] a,
         input logic [7:0] c, input logic [7:0] v, input logic nk);
      apb(1'b1, `CBS_A_XFER, {11'h000, 5'h01, c, 1'b0, a});
      apb(1'b1, `CBS_A_DATA, {24'h00_0000, v});
      apb(1'b1, `CBS_A_CTRL, {29'h0000_0000, op, 1'b1});
      q = 32'h0000_0001;
      for (int i = 0; i < 100000 && q[0] !== 1'b0; i++)
         apb(1'b0, `CBS_A_STAT, 32'h0000_0000);
      chk("busy nack", {30'h0000_0000, nk, 1'b0},
         {30'h0000_0000, q[1:0]});
   endtask
   task automatic outs(input logic [7:0] b23, input logic [7:0] b22);
      logic [5:0] ea;
      logic [5:0] eb;
      logic r;
      ea = b23[5:0];
      eb = {b22[3:0], b23[7:6]};
      for (int i = 0; i < 2; i++) begin
         r = i[0];
         ra <= r;
         rb <= ~r;
         repeat (4) @(posedge pclk);
         chk("outputs", {6'h00, ea & {6{r}}, ea & {6{~r}}, eb & {6{~r}},
            eb & {6{r}}, r & ~b22[5], ~r & ~b22[4]},
            {6'h00, at, ac, bt, bc, fa, fb});
      end
   endtask
   // ---
   // scenarios
   // ---
   task automatic t_defaults();
      outs(8'hff, 8'h0f);
   endtask
   task automatic t_byte();
      run(2'h0, 7'h6e, 8'hb7, 8'h5a, 1'b0);
      outs(8'h5a, 8'h0f);
      run(2'h1, 7'h6e, 8'hb7, 8'h00, 1'b0);
      apb(1'b0, `CBS_A_DATA, 32'h0000_0000);
      chk("read byte", 32'h0000_005a, {24'h00_0000, q[7:0]});
   endtask
   task automatic t_refuse();
      run(2'h0, 7'h6e, 8'hd7, 8'h00, 1'b1);
      run(2'h0, 7'h69, 8'hb7, 8'h00, 1'b1);
      outs(8'h5a, 8'h0f);
   endtask
   task automatic t_block();
      run(2'h2, 7'h6e, 8'h20, 8'ha5, 1'b0);
      run(2'h3, 7'h6e, 8'h20, 8'h00, 1'b0);
      chk("count", 32'h0000_0018, {24'h00_0000, q[15:8]});
      apb(1'b0, `CBS_A_DATA, 32'h0000_0000);
      chk("block byte", 32'h0000_00a5, {24'h00_0000, q[7:0]});
      outs(8'h5a, 8'h0f);
   endtask
   task automatic t_alt();
      address_choice_pin <= 1'b1;
      device_select_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      run(2'h0, 7'h69, 8'hd6, 8'h35, 1'b0);
      outs(8'h5a, 8'h35);
   endtask
   // a second reset must bring back the defaults after writes
   task automatic t_reset();
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      outs(8'hff, 8'h0f);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_byte();
      t_refuse();
      t_block();
      t_alt();
      t_reset();
      wrap_up();
   end
   // about 214 bit times of 312 cycles each, plus margin
   initial begin
      repeat (90000) @(posedge pclk);
      failures++;
      wrap_up();
   end
endmodule
`default_nettype wire
